// file: hw/pmt_pkg.sv
package pmt_pkg;

	// -----------------------------------------------------------------
	// bus addresses and command codes
	// -----------------------------------------------------------------
	localparam logic [6:0] ADDR_BASE = 7'h10;
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	localparam int STRAP_W = 5;
	localparam logic [7:0] CMD_STORE_ALL = 8'h15;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] IDLE_FILL = 8'hFF;

	// -----------------------------------------------------------------
	// bit positions inside one byte slot (counted on bus clock rises)
	// -----------------------------------------------------------------
	localparam logic [3:0] BIT_LSB_NEXT = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_DONE = 4'h9;
	localparam logic [1:0] BLOCK_STRIDE_LAST = 2'h3;
	localparam logic [7:0] BLOCK_MIN_LEN = 8'h04;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int STRETCH_NS = 400;
	localparam int STRETCH_CYC = (STRETCH_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_W = 8;

	// -----------------------------------------------------------------
	// transaction states, gray along idle-addr-cmd-wdata-rdata
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_CMD = 3'h3,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h6,
		ST_IGNORE = 3'h4
	} pmt_state_t;

endpackage

// file: hw/pmt_byte_if.sv
`timescale 1ns/100ps

// -----------------------------------------------------------------
// byte stream into the checksum unit
// -----------------------------------------------------------------
interface pmt_byte_if;
	logic clr;
	logic vld;
	logic [7:0] data;
	logic [7:0] crc;

	modport source (output clr, output vld, output data, input crc);
	modport crc_unit (input clr, input vld, input data, output crc);
endinterface

// file: hw/pmt_pec_crc.sv
`timescale 1ns/100ps

module pmt_pec_crc (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	pmt_byte_if.crc_unit bif
);

	logic [7:0] crc_q;
	logic [7:0] crc_d;

	// -----------------------------------------------------------------
	// crc-8 over one byte, msb first
	// -----------------------------------------------------------------
	always_comb begin
		crc_d = crc_q ^ bif.data;
		for (int i = 0; i < 8; i++) begin
			crc_d = crc_d[7] ? ({crc_d[6:0], 1'b0} ^ pmt_pkg::CRC_POLY) : {crc_d[6:0], 1'b0};
		end
	end

	// clear wins over a byte in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			crc_q <= pmt_pkg::CRC_INIT;
		end else if (ce) begin
			if (bif.clr) begin
				crc_q <= pmt_pkg::CRC_INIT;
			end else if (bif.vld) begin
				crc_q <= crc_d;
			end
		end
	end

	assign bif.crc = crc_q;

endmodule

// file: hw/pmt_target.sv
// Notes on behaviour
// - Bus timing works at 100 kHz, 400 kHz and 1 MHz; host picks any.
// - Never hold the bus clock low during the target address byte.
// - May hold clock low after command byte bit 0, before its acknowledge.
// - Hold clock low after bit 0 of the repeated read address (held only for nonzero CMD_LEN, until read data is ready).
// - Hold clock low between bit 0 of the final data byte and its acknowledge.
// - Blocks over four bytes: may hold between bit 1 and 0 of every fourth byte.
// - Checksum counts only if host clocks the extra byte before stop.
// - With require-checksum set, reject writes that end without checksum byte.
// - While alerting, acknowledge alert response read and return own address.
// - After alert response, reassert alert if a non-communication fault persists.
// - Settings stay volatile; stored to non-volatile memory only by store-all command.
// - Default source select picks strap values or non-volatile memory at power-on.
// - Bus address comes from address strap: 32 addresses, 0x10 to 0x2F.
// - Programming mode answers bus commands while switching stays disabled.
`timescale 1ns/100ps

module pmt_target #(
	parameter int HOLD_CYC = pmt_pkg::STRETCH_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CLK_EN,
	input wire logic BUS_CLOCK_PIN_I,
	output logic BUS_CLOCK_PIN_O,
	output logic BUS_CLOCK_PIN_OE,
	input wire logic BUS_DATA_PIN_I,
	output logic BUS_DATA_PIN_O,
	output logic BUS_DATA_PIN_OE,
	output logic ALERT_OUTPUT_PIN_O,
	output logic ALERT_OUTPUT_PIN_OE,
	input wire logic [4:0] ADDRESS_STRAP_PIN,
	input wire logic CONTROL_INPUT_SUPPLY_OK,
	input wire logic POWER_INPUT_SUPPLY_OK,
	input wire logic REQUIRE_PEC,
	input wire logic DEFAULT_SOURCE_SELECT,
	input wire logic ALERT_PENDING,
	input wire logic FAULT_PERSIST,
	input wire logic SWITCH_REQ,
	input wire logic [7:0] CMD_LEN,
	input wire logic RD_READY,
	input wire logic [7:0] RD_DATA,
	output logic [7:0] CMD_CODE,
	output logic WR_STROBE,
	output logic [7:0] WR_DATA,
	output logic [7:0] WR_INDEX,
	output logic WR_DONE,
	output logic WR_REJECT,
	output logic RD_REQ,
	output logic [7:0] RD_INDEX,
	output logic STORE_REQ,
	output logic [6:0] BUS_ADDRESS,
	output logic DEFAULTS_FROM_NVM,
	output logic DEFAULTS_LOAD,
	output logic PROGRAMMING_MODE,
	output logic SWITCH_ENABLE
);

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	logic [4:0] strap_m_q, strap_s_q;
	logic [1:0] sup_m_q, sup_s_q;

	// two flops per pin, then a history flop on the bus clock and data pins for edge finding
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
			strap_m_q <= 5'h00;
			strap_s_q <= 5'h00;
			sup_m_q <= 2'h0;
			sup_s_q <= 2'h0;
		end else if (CLK_EN) begin
			{scl_m_q, scl_s_q, scl_p_q} <= {BUS_CLOCK_PIN_I, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {BUS_DATA_PIN_I, sda_m_q, sda_s_q};
			strap_m_q <= ADDRESS_STRAP_PIN;
			strap_s_q <= strap_m_q;
			sup_m_q <= {POWER_INPUT_SUPPLY_OK, CONTROL_INPUT_SUPPLY_OK};
			sup_s_q <= sup_m_q;
		end
	end

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	pmt_pkg::pmt_state_t st_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] sh_q, tx_q, nxt_q, idx_q, cmd_q;
	logic [7:0] wr_dat_q, wr_idx_q, rd_idx_q, crc_dat_q;
	logic [pmt_pkg::HOLD_W-1:0] hold_cnt_q;
	logic had_cmd_q, ara_q, nack_q, wait_rd_q, sda_oe_q, scl_oe_q;
	logic nxt_ok_q, rd_pend_q, crc_vld_q, crc_clr_q;
	logic wr_stb_q, done_q, rej_q, store_q, rd_req_q, ara_srv_q;
	logic served_q, alert_q, prog_q, sw_en_q, nvm_q, load_q, strap_done_q;
	logic [1:0] strap_cnt_q;
	logic [6:0] own_addr_q;

	pmt_byte_if crc_bus ();

	// -----------------------------------------------------------------
	// bus event decode, sampled at 125 per bit even at 1 MHz
	// -----------------------------------------------------------------
	wire scl_rise = scl_s_q & ~scl_p_q;
	wire scl_fall = ~scl_s_q & scl_p_q;
	wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	wire active = (st_q != pmt_pkg::ST_IDLE) && (st_q != pmt_pkg::ST_IGNORE);
	wire byte_done = scl_fall && active && (bit_cnt_q == pmt_pkg::BIT_ACK);
	wire ack_done = scl_fall && active && (bit_cnt_q == pmt_pkg::BIT_DONE);
	wire bit_fall = scl_fall && active && (bit_cnt_q < pmt_pkg::BIT_ACK);
	wire addr_me = sh_q[7:1] == own_addr_q;
	wire addr_ara = (sh_q[7:1] == pmt_pkg::ARA_ADDR) && alert_q;
	wire block_mid = (st_q == pmt_pkg::ST_WDATA) && (idx_q[1:0] == pmt_pkg::BLOCK_STRIDE_LAST)
		&& (CMD_LEN > pmt_pkg::BLOCK_MIN_LEN);

	// -----------------------------------------------------------------
	// checksum presence at stop and next byte to send
	// -----------------------------------------------------------------
	wire n_pec = {1'b0, idx_q} == ({1'b0, CMD_LEN} + 9'h001);
	wire n_plain = idx_q == CMD_LEN;
	wire pec_good = crc_bus.crc == pmt_pkg::CRC_INIT;
	wire commit_ok = (n_pec && pec_good) || (n_plain && !REQUIRE_PEC);
	wire wr_end = stop_det && (st_q == pmt_pkg::ST_WDATA);
	wire [7:0] data_src = (idx_q == CMD_LEN) ? crc_bus.crc :
		((idx_q < CMD_LEN) && nxt_ok_q) ? nxt_q : pmt_pkg::IDLE_FILL;
	wire [7:0] ara_src = (idx_q == 8'h00) ? {own_addr_q, 1'b0} : pmt_pkg::IDLE_FILL;
	wire [7:0] tx_src = ara_q ? ara_src : data_src;
	wire load_tx = ack_done && (st_q == pmt_pkg::ST_RDATA) && !nack_q;
	wire [7:0] idx_inc = idx_q + 8'h01;
	wire pref_req = !ara_q && (idx_inc < CMD_LEN);

	// -----------------------------------------------------------------
	// transaction engine
	// -----------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_q <= pmt_pkg::ST_IDLE;
			bit_cnt_q <= 4'h0;
			{sh_q, tx_q, idx_q, cmd_q} <= 32'h0000_0000;
			{wr_dat_q, wr_idx_q, rd_idx_q, crc_dat_q} <= 32'h0000_0000;
			hold_cnt_q <= '0;
			{had_cmd_q, ara_q, nack_q, wait_rd_q, sda_oe_q} <= 5'h00;
			{crc_vld_q, crc_clr_q, wr_stb_q, done_q, rej_q} <= 5'h00;
			{store_q, rd_req_q, ara_srv_q} <= 3'h0;
		end else if (CLK_EN) begin
			{crc_vld_q, crc_clr_q, wr_stb_q, done_q, rej_q} <= 5'h00;
			{store_q, rd_req_q, ara_srv_q} <= 3'h0;
			if (hold_cnt_q != '0) begin
				hold_cnt_q <= hold_cnt_q - 1'b1;
			end
			if (wait_rd_q && nxt_ok_q) begin
				wait_rd_q <= 1'b0;
			end
			if (start_det) begin
				st_q <= pmt_pkg::ST_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
				crc_clr_q <= !had_cmd_q;
			end else if (stop_det) begin
				st_q <= pmt_pkg::ST_IDLE;
				had_cmd_q <= 1'b0;
				sda_oe_q <= 1'b0;
				done_q <= wr_end && commit_ok;
				rej_q <= wr_end && !commit_ok;
				store_q <= wr_end && commit_ok && (cmd_q == pmt_pkg::CMD_STORE_ALL);
			end else if (scl_rise && active && (bit_cnt_q < pmt_pkg::BIT_DONE)) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
				if (bit_cnt_q < pmt_pkg::BIT_ACK) begin
					sh_q <= {sh_q[6:0], sda_s_q};
				end else begin
					nack_q <= sda_s_q;
				end
			end else if (byte_done) begin
				case (st_q)
					pmt_pkg::ST_ADDR: begin
						crc_vld_q <= 1'b1;
						crc_dat_q <= sh_q;
						ara_q <= sh_q[0] && addr_ara;
						idx_q <= 8'h00;
						if (sh_q[0] && addr_ara) begin
							sda_oe_q <= 1'b1;
							st_q <= pmt_pkg::ST_RDATA;
						end else if (sh_q[0] && addr_me && had_cmd_q) begin
							sda_oe_q <= 1'b1;
							st_q <= pmt_pkg::ST_RDATA;
							wait_rd_q <= CMD_LEN != 8'h00;
							rd_req_q <= CMD_LEN != 8'h00;
							rd_idx_q <= 8'h00;
						end else if (!sh_q[0] && addr_me) begin
							sda_oe_q <= 1'b1; // no hold here
							st_q <= pmt_pkg::ST_CMD;
						end else begin
							st_q <= pmt_pkg::ST_IGNORE;
						end
					end
					pmt_pkg::ST_CMD: begin
						crc_vld_q <= 1'b1;
						crc_dat_q <= sh_q;
						cmd_q <= sh_q;
						had_cmd_q <= 1'b1;
						idx_q <= 8'h00;
						sda_oe_q <= 1'b1;
						hold_cnt_q <= pmt_pkg::HOLD_W'(HOLD_CYC);
						st_q <= pmt_pkg::ST_WDATA;
					end
					pmt_pkg::ST_WDATA: begin
						crc_vld_q <= 1'b1;
						crc_dat_q <= sh_q;
						wr_stb_q <= 1'b1;
						wr_dat_q <= sh_q;
						wr_idx_q <= idx_q;
						idx_q <= idx_inc;
						sda_oe_q <= 1'b1;
						hold_cnt_q <= pmt_pkg::HOLD_W'(HOLD_CYC);
					end
					pmt_pkg::ST_RDATA: begin
						sda_oe_q <= 1'b0;
						ara_srv_q <= ara_q;
					end
					default: begin
						sda_oe_q <= 1'b0;
					end
				endcase
			end else if (ack_done) begin
				bit_cnt_q <= 4'h0;
				if (load_tx) begin
					tx_q <= tx_src;
					sda_oe_q <= !tx_src[7];
					crc_vld_q <= 1'b1;
					crc_dat_q <= tx_src;
					idx_q <= idx_inc;
					rd_req_q <= pref_req;
					rd_idx_q <= idx_inc;
				end else if (st_q == pmt_pkg::ST_RDATA) begin
					sda_oe_q <= 1'b0;
					st_q <= pmt_pkg::ST_IGNORE;
				end else begin
					sda_oe_q <= 1'b0;
				end
			end else if (bit_fall) begin
				if (st_q == pmt_pkg::ST_RDATA) begin
					sda_oe_q <= !tx_q[3'(4'h7 - bit_cnt_q)];
				end
				if (block_mid && (bit_cnt_q == pmt_pkg::BIT_LSB_NEXT)) begin
					hold_cnt_q <= pmt_pkg::HOLD_W'(HOLD_CYC);
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// read data prefetch and clock hold
	// -----------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			nxt_q <= 8'h00;
			nxt_ok_q <= 1'b0;
			rd_pend_q <= 1'b0;
			scl_oe_q <= 1'b0;
		end else if (CLK_EN) begin
			rd_pend_q <= rd_req_q || (rd_pend_q && !RD_READY);
			if (rd_pend_q && RD_READY) begin
				nxt_q <= RD_DATA;
				nxt_ok_q <= 1'b1;
			end else if (load_tx || start_det) begin
				nxt_ok_q <= 1'b0;
			end
			scl_oe_q <= (hold_cnt_q != '0) || wait_rd_q;
		end
	end

	// -----------------------------------------------------------------
	// alert line, response handshake sets served, set wins over clear
	// -----------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			served_q <= 1'b0;
			alert_q <= 1'b0;
		end else if (CLK_EN) begin
			served_q <= ara_srv_q || (served_q && ALERT_PENDING);
			alert_q <= ALERT_PENDING && (!served_q || FAULT_PERSIST);
		end
	end

	// -----------------------------------------------------------------
	// strap capture after reset, defaults source, supply modes
	// -----------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
			own_addr_q <= pmt_pkg::ADDR_BASE;
			nvm_q <= 1'b0;
			load_q <= 1'b0;
			prog_q <= 1'b0;
			sw_en_q <= 1'b0;
		end else if (CLK_EN) begin
			load_q <= 1'b0;
			if (!strap_done_q) begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
				if (strap_cnt_q == pmt_pkg::STRAP_SETTLE) begin
					own_addr_q <= pmt_pkg::ADDR_BASE + {2'b00, strap_s_q};
					nvm_q <= DEFAULT_SOURCE_SELECT;
					load_q <= 1'b1;
					strap_done_q <= 1'b1;
				end
			end
			prog_q <= sup_s_q[0] && !sup_s_q[1];
			sw_en_q <= SWITCH_REQ && sup_s_q[0] && sup_s_q[1];
		end
	end

	// -----------------------------------------------------------------
	// checksum unit and outputs
	// -----------------------------------------------------------------
	assign crc_bus.clr = crc_clr_q;
	assign crc_bus.vld = crc_vld_q;
	assign crc_bus.data = crc_dat_q;

	pmt_pec_crc u_crc (
		.clk(SYS_CLK),
		.rst(RST),
		.ce(CLK_EN),
		.bif(crc_bus)
	);

	assign BUS_CLOCK_PIN_O = 1'b0;
	assign BUS_CLOCK_PIN_OE = scl_oe_q;
	assign BUS_DATA_PIN_O = 1'b0;
	assign BUS_DATA_PIN_OE = sda_oe_q;
	assign ALERT_OUTPUT_PIN_O = 1'b0;
	assign ALERT_OUTPUT_PIN_OE = alert_q;
	assign CMD_CODE = cmd_q;
	assign WR_STROBE = wr_stb_q;
	assign WR_DATA = wr_dat_q;
	assign WR_INDEX = wr_idx_q;
	assign WR_DONE = done_q;
	assign WR_REJECT = rej_q;
	assign RD_REQ = rd_req_q;
	assign RD_INDEX = rd_idx_q;
	assign STORE_REQ = store_q;
	assign BUS_ADDRESS = own_addr_q;
	assign DEFAULTS_FROM_NVM = nvm_q;
	assign DEFAULTS_LOAD = load_q;
	assign PROGRAMMING_MODE = prog_q;
	assign SWITCH_ENABLE = sw_en_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST || !CLK_EN);

	chk_addr_no_stretch: assert property ((st_q == pmt_pkg::ST_ADDR) |-> !BUS_CLOCK_PIN_OE)
		else $error("clock held during address byte");
	chk_cmd_ack_hold: assert property (byte_done && st_q == pmt_pkg::ST_CMD |->
		##2 (BUS_CLOCK_PIN_OE && BUS_DATA_PIN_OE) [*8]) else $error("no hold after command byte");
	chk_read_addr_hold: assert property ($rose(wait_rd_q) |-> ##1 (BUS_CLOCK_PIN_OE && BUS_DATA_PIN_OE))
		else $error("no hold after read address");
	chk_data_ack_hold: assert property (byte_done && st_q == pmt_pkg::ST_WDATA |->
		##2 (BUS_CLOCK_PIN_OE && BUS_DATA_PIN_OE) [*8]) else $error("no hold after data byte");
	chk_block_bit_hold: assert property (bit_fall && block_mid && bit_cnt_q == 4'h7 |->
		##2 BUS_CLOCK_PIN_OE [*8]) else $error("no hold inside fourth block byte");
	chk_pec_commit: assert property (wr_end && n_pec && pec_good |=> WR_DONE && !WR_REJECT)
		else $error("good checksum write not committed");
	chk_require_pec: assert property (wr_end && n_plain && REQUIRE_PEC |=> WR_REJECT && !WR_DONE)
		else $error("write without checksum accepted");
	chk_ara_ack: assert property (byte_done && st_q == pmt_pkg::ST_ADDR && sh_q[0] && addr_ara |=>
		BUS_DATA_PIN_OE && st_q == pmt_pkg::ST_RDATA) else $error("alert response not acknowledged");
	chk_alert_rearm: assert property (ara_srv_q && ALERT_PENDING && FAULT_PERSIST
		##1 (ALERT_PENDING && FAULT_PERSIST) |=> ALERT_OUTPUT_PIN_OE) else $error("alert not reasserted");
	chk_alert_release: assert property (ara_srv_q && !FAULT_PERSIST ##1 !FAULT_PERSIST |=>
		!ALERT_OUTPUT_PIN_OE) else $error("alert not released after response");
	chk_store_cmd: assert property (STORE_REQ |-> WR_DONE && CMD_CODE == pmt_pkg::CMD_STORE_ALL)
		else $error("store request without store command");
	chk_default_src: assert property ($rose(strap_done_q) |-> DEFAULTS_FROM_NVM == $past(DEFAULT_SOURCE_SELECT))
		else $error("defaults source not captured");
	chk_strap_addr: assert property ($rose(strap_done_q) |-> BUS_ADDRESS == pmt_pkg::ADDR_BASE + $past(strap_s_q))
		else $error("bus address not from strap");
	chk_prog_no_switch: assert property (PROGRAMMING_MODE |-> !SWITCH_ENABLE)
		else $error("switching enabled in programming mode");

endmodule

// file: test/pmt_host_model.sv
`timescale 1ns/100ps

// -----------------------------------------------------------------
// host controller on the management bus
// -----------------------------------------------------------------
module pmt_host_model #(
	parameter int LOW_NS = 40,
	parameter int HIGH_NS = 24
) (
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	logic stretched;

	// both lines start released, pull-ups hold them high
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		stretched = 1'b0;
	end

	// one bit: data set in the low phase, sampled late in the high phase
	// low phase outlasts the target's hold delay, so a hold shows before release
	task automatic bit_io(input logic b, output logic r);
		#8 sda_low = !b;
		#(LOW_NS - 8) scl_low = 1'b0;
		#1;
		if (scl !== 1'b1) stretched = 1'b1;
		wait (scl === 1'b1);
		#(HIGH_NS - 1) r = sda;
		scl_low = 1'b1;
	endtask

	// eight bits msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ack_in, ack_out);
	endtask

	task automatic start();
		sda_low = 1'b1;
		#HIGH_NS scl_low = 1'b1;
	endtask

	// data moves while the clock is high: low first gives stop, high first restart
	task automatic edge_cond(input logic first_low);
		#8 sda_low = first_low;
		#(LOW_NS - 8) scl_low = 1'b0;
		wait (scl === 1'b1);
		#HIGH_NS sda_low = !first_low;
	endtask

	task automatic restart();
		edge_cond(1'b0);
		#HIGH_NS scl_low = 1'b1;
	endtask

	// checksum clocks or a stop are the caller's choice
	task automatic stop();
		edge_cond(1'b1);
		#(LOW_NS + HIGH_NS);
	endtask
endmodule

// file: test/tb_pmt_target.sv
`timescale 1ns/100ps

// -----------------------------------------------------------------
// bench for the bus target
// -----------------------------------------------------------------
module tb_pmt_target;
	logic sys_clk, rst, scl_low, sda_low, scl, sda, clk_oe, sda_oe, alert_oe;
	logic wr_strobe, wr_done, wr_reject, rd_req, store_req, dload, prog, sw_en, nvm;
	logic ctl_ok, pwr_ok, req_pec, alert_pend, fault_p, sw_req, rd_ready, aack, k, dsrc;
	logic [7:0] wr_index, last_idx;
	logic [4:0] strap;
	logic [6:0] own;
	logic [7:0] cmd_code, len_sel, cmd_len, rd_data, wr_data, rd_index, last_wr, q, r;
	int bad_count = 0;
	int checks = 0;
	int n_done = 0;
	int n_rej = 0;
	int n_store = 0;
	int n_load = 0;

	// open-drain wires with pull-ups; store-all carries no data
	assign scl = !(scl_low | clk_oe);
	assign sda = !(sda_low | sda_oe);
	assign cmd_len = (cmd_code === pmt_pkg::CMD_STORE_ALL) ? 8'h00 : len_sel;

	pmt_target #(.HOLD_CYC(8)) i_pmt_target (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(1'b1),
		.BUS_CLOCK_PIN_I(scl), .BUS_CLOCK_PIN_O(), .BUS_CLOCK_PIN_OE(clk_oe), .BUS_DATA_PIN_I(sda),
		.BUS_DATA_PIN_O(), .BUS_DATA_PIN_OE(sda_oe), .ALERT_OUTPUT_PIN_O(), .ALERT_OUTPUT_PIN_OE(alert_oe),
		.ADDRESS_STRAP_PIN(strap), .CONTROL_INPUT_SUPPLY_OK(ctl_ok), .POWER_INPUT_SUPPLY_OK(pwr_ok),
		.REQUIRE_PEC(req_pec), .DEFAULT_SOURCE_SELECT(dsrc), .ALERT_PENDING(alert_pend), .FAULT_PERSIST(fault_p),
		.SWITCH_REQ(sw_req), .CMD_LEN(cmd_len), .RD_READY(rd_ready), .RD_DATA(rd_data), .CMD_CODE(cmd_code),
		.WR_STROBE(wr_strobe), .WR_DATA(wr_data), .WR_INDEX(wr_index), .WR_DONE(wr_done), .WR_REJECT(wr_reject),
		.RD_REQ(rd_req), .RD_INDEX(rd_index), .STORE_REQ(store_req), .BUS_ADDRESS(own),
		.DEFAULTS_FROM_NVM(nvm), .DEFAULTS_LOAD(dload), .PROGRAMMING_MODE(prog), .SWITCH_ENABLE(sw_en));
	pmt_host_model i_pmt_host_model (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// read data source and pulse counters
	always @(posedge sys_clk) begin
		rd_ready <= rd_req;
		rd_data <= 8'hA0 + rd_index;
		if (wr_strobe) begin
			last_wr <= wr_data;
			last_idx <= wr_index;
		end
		n_done <= n_done + int'(wr_done);
		n_rej <= n_rej + int'(wr_reject);
		n_store <= n_store + int'(store_req);
		n_load <= n_load + int'(dload);
	end

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++) x = x[7] ? ({x[6:0], 1'b0} ^ pmt_pkg::CRC_POLY) : {x[6:0], 1'b0};
		return x;
	endfunction

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// write: address, bytes, optional checksum over all bytes from the address
	task automatic wr(input logic [6:0] a, input logic [7:0] b[$], input logic pec);
		logic [7:0] c;
		c = crc8(pmt_pkg::CRC_INIT, {a, 1'b0});
		i_pmt_host_model.stretched = 1'b0;
		i_pmt_host_model.start();
		i_pmt_host_model.xfer({a, 1'b0}, 1'b1, q, aack);
		chk("address hold", {7'h00, i_pmt_host_model.stretched}, 8'h00);
		foreach (b[i]) begin
			c = crc8(c, b[i]);
			i_pmt_host_model.stretched = 1'b0;
			i_pmt_host_model.xfer(b[i], 1'b1, q, k);
		end
		chk("last byte hold", {7'h00, i_pmt_host_model.stretched}, 8'h01);
		if (pec) i_pmt_host_model.xfer(c, 1'b1, q, k);
		i_pmt_host_model.stop();
		repeat (8) @(posedge sys_clk);
	endtask

	// combined read: command, repeated start, n bytes, then the checksum
	task automatic rd(input logic [6:0] a, input logic [7:0] cmd, input int n);
		logic [7:0] c;
		c = crc8(crc8(crc8(pmt_pkg::CRC_INIT, {a, 1'b0}), cmd), {a, 1'b1});
		i_pmt_host_model.start();
		i_pmt_host_model.xfer({a, 1'b0}, 1'b1, q, aack);
		i_pmt_host_model.xfer(cmd, 1'b1, q, k);
		i_pmt_host_model.restart();
		i_pmt_host_model.stretched = 1'b0;
		i_pmt_host_model.xfer({a, 1'b1}, 1'b1, q, k);
		chk("read address hold", {7'h00, i_pmt_host_model.stretched}, 8'h01);
		for (int i = 0; i < n; i++) begin
			i_pmt_host_model.xfer(8'hFF, 1'b0, q, k);
			chk("read byte", q, 8'hA0 + i[7:0]);
			c = crc8(c, q);
		end
		i_pmt_host_model.xfer(8'hFF, 1'b1, q, k);
		chk("read checksum", q, c);
		i_pmt_host_model.stop();
	endtask

	// alert response read: one byte back from the response address
	task automatic ara();
		r = 8'hFF;
		i_pmt_host_model.start();
		i_pmt_host_model.xfer({pmt_pkg::ARA_ADDR, 1'b1}, 1'b1, q, aack);
		if (aack === 1'b0) i_pmt_host_model.xfer(8'hFF, 1'b1, r, k);
		i_pmt_host_model.stop();
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog: several times what the sequence needs
	initial begin
		#400_000;
		bad_count++;
		$display("Error watchdog expected finish seen timeout");
		end_of_test();
	end

	initial begin
		{rst, ctl_ok, pwr_ok, sw_req, req_pec, alert_pend, fault_p, rd_ready} = 8'hF0;
		strap = 5'h1F;
		dsrc = 1'b1;
		len_sel = 8'h02;
		rd_data = 8'h00;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk("bus address", {1'b0, own}, 8'h2F);
		chk("defaults source", {7'h00, nvm}, 8'h01);
		chk("defaults load", n_load[7:0], 8'h01);
		$display("test strap done");
		wr(7'h2F, '{8'h21, 8'h34, 8'h12}, 1'b0);
		chk("write ack", {7'h00, aack}, 8'h00);
		chk("last data", last_wr, 8'h12);
		chk("last index", last_idx, 8'h01);
		chk("commit plain", n_done[7:0] ^ n_store[7:0], 8'h01);
		wr(7'h2F, '{pmt_pkg::CMD_STORE_ALL}, 1'b0); // store-all alone, no data; the store does not depend on supplies
		chk("store count", n_store[7:0], 8'h01);
		$display("test write done");
		@(posedge sys_clk) req_pec <= 1'b1;
		wr(7'h2F, '{8'h21, 8'h34, 8'h12}, 1'b0);
		chk("reject no checksum", n_rej[7:0], 8'h01);
		wr(7'h2F, '{8'h21, 8'h34, 8'h12}, 1'b1);
		len_sel <= 8'h05;
		wr(7'h2F, '{8'h30, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05}, 1'b1);
		chk("commit checksum", n_done[7:0], 8'h04);
		chk("checksum index", last_idx, 8'h05);
		$display("test checksum done");
		i_pmt_host_model.start();
		i_pmt_host_model.xfer(8'h5C, 1'b1, q, aack);
		i_pmt_host_model.stop();
		chk("foreign address nack", {7'h00, aack}, 8'h01);
		@(posedge sys_clk) len_sel <= 8'h02;
		rd(7'h2F, 8'h8B, 2);
		$display("test read done");
		@(posedge sys_clk) {alert_pend, fault_p} <= 2'b11;
		repeat (6) @(posedge sys_clk);
		chk("alert raised", {7'h00, alert_oe}, 8'h01);
		ara();
		chk("alert response", r, {own, 1'b0});
		chk("alert persists", {7'h00, alert_oe}, 8'h01);
		@(posedge sys_clk) fault_p <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("alert released", {7'h00, alert_oe}, 8'h00);
		@(posedge sys_clk) alert_pend <= 1'b0;
		ara();
		chk("idle response nack", {7'h00, aack}, 8'h01);
		@(posedge sys_clk) alert_pend <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("alert again", {7'h00, alert_oe}, 8'h01);
		ara();
		chk("second response", r, {own, 1'b0});
		chk("alert cleared", {7'h00, alert_oe}, 8'h00);
		$display("test alert done");
		@(posedge sys_clk) {pwr_ok, req_pec} <= 2'b00;
		repeat (8) @(posedge sys_clk);
		chk("programming mode", {6'h00, prog, sw_en}, 8'h02);
		wr(7'h2F, '{8'h21, 8'h55, 8'h66}, 1'b0);
		chk("programming commit", n_done[7:0], 8'h05);
		@(posedge sys_clk) pwr_ok <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("switching", {6'h00, prog, sw_en}, 8'h01);
		$display("test programming done");
		@(posedge sys_clk) {rst, dsrc, alert_pend} <= 3'b100;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk("strap source", {7'h00, nvm}, 8'h00);
		chk("second load", n_load[7:0], 8'h02);
		chk("address after reset", {1'b0, own}, 8'h2F);
		$display("test reset done");
		end_of_test();
	end
endmodule
